/* asfl_consts.svh */
`ifndef ASFL_CONSTS_SVH
`define ASFL_CONSTS_SVH

// register byte offsets on the apb bus
`define ASFL_PSW_OFFSET 8'h00
`define ASFL_IRQ_OFFSET 8'h04

// processor_status_word field positions
`define ASFL_N_BIT 0
`define ASFL_C_BIT 1
`define ASFL_V_BIT 2
`define ASFL_Z_BIT 3
`define ASFL_E_BIT 4
`define ASFL_MUL_IN_PROGRESS_FLAG_BIT 5
`define ASFL_USR0_BIT 6
`define ASFL_USR1_BIT 7
`define ASFL_BANK_LSB 8
`define ASFL_HLDEN_BIT 10
`define ASFL_IEN_BIT 11
`define ASFL_LVL_LSB 12

// reset value and constants of the flag logic
`define ASFL_PSW_RESET 16'h0000
`define ASFL_LVL_TOP 4'hF
`define ASFL_MIN_WORD 16'h8000
`define ASFL_MIN_BYTE 8'h80
`define ASFL_BANK_RSVD 2'h1

`endif

/* asfl_pkg.sv */
package asfl_pkg;

  typedef enum logic [3:0] {
    ASFL_OP_ADD = 4'h0,
    ASFL_OP_SUB = 4'h1,
    ASFL_OP_NEG = 4'h2,
    ASFL_OP_LOGIC = 4'h3,
    ASFL_OP_MUL = 4'h4,
    ASFL_OP_DIV = 4'h5,
    ASFL_OP_SHL = 4'h6,
    ASFL_OP_SHR = 4'h7,
    ASFL_OP_PRIOR = 4'h8,
    ASFL_OP_BIT1 = 4'h9,
    ASFL_OP_BIT2 = 4'hA,
    ASFL_OP_MOVE = 4'hB
  } asfl_kind_e;

  typedef struct packed {
    logic [3:0] lvl;
    logic global_interrupt_enable;
    logic hlden;
    logic [1:0] bank;
    logic usr1;
    logic usr0;
    logic mul_in_progress_flag;
    logic e;
    logic z;
    logic v;
    logic c;
    logic n;
  } asfl_psw_s;

  // one completed instruction from the execution stage
  typedef struct packed {
    logic valid;
    asfl_kind_e kind;
    logic byte_op;
    logic with_carry;
    logic table_src;
    logic signed_op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
    logic [31:0] wide_res;
    logic div_zero;
    logic div_ovf;
    logic [4:0] shift_cnt;
    logic shift_out;
    logic shift_sticky;
    logic bit_x;
    logic bit_y;
  } asfl_op_s;

  typedef struct packed {
    logic entry;
    logic [1:0] bank;
    logic [3:0] lvl;
    logic return_from_interrupt_instruction;
    logic [15:0] saved;
  } asfl_irq_s;

  typedef struct packed {
    asfl_psw_s psw;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_ok;
  } asfl_state_s;

endpackage

/* asfl_psw.sv */
// Behaviour
// - explicit status word write beats implicit flags
// - reads return status after preceding instruction
// - reset clears N C V Z E and multiply flag
// - N is result msb for operand size
// - bit ops: N prior bit, or XOR
// - carry on add, inverted carry on subtract
// - logical, multiply, divide clear carry
// - shifts: carry last bit out; prioritize clears
// - bit ops: carry cleared, or AND
// - add, sub, negate set signed overflow
// - multiply, divide overflow; divide by zero
// - logical operations clear overflow
// - right shifts: overflow is sticky rounding bit
// - bit ops: overflow cleared, or OR
// - zero flag set on zero result
// - carry-chained ops keep zero only if zero
// - bit ops and prioritize special zero flag
// - table-capable ops set E on minimum value
// - multiply-in-progress flag always reads zero
// - bank loaded on entry, return, software write
// - enable and priority level gate interrupts
// - reset disables interrupts, priority level zero
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "asfl_consts.svh"

module asfl_psw
  import asfl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution stage
  input wire asfl_op_s op,
  input wire asfl_irq_s irq,
  // interrupt request to be judged
  input wire logic req_valid,
  input wire logic [3:0] req_lvl,
  input wire logic req_unmaskable,
  // status towards the cpu
  output logic [15:0] processor_status_word,
  output logic irq_ok
);

  localparam asfl_state_s RESET_ST = '{
    psw: asfl_psw_s'(`ASFL_PSW_RESET),
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    irq_ok: 1'b0
  };

  asfl_state_s st;
  asfl_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // flag arithmetic

  logic [15:0] opa;
  logic [15:0] opb;
  logic cin;
  logic [16:0] carry;
  logic [15:0] bit_sum;
  logic [15:0] sum;
  logic add_carry;
  logic msb_a;
  logic msb_b;
  logic msb_s;
  logic msb_r;
  logic zero_s;
  logic zero_r;
  logic mul_v;
  logic min_src;
  asfl_psw_s f;

  always_comb begin
    opa = op.a;
    opb = op.b;
    cin = 1'b0;
    unique case (op.kind)
      ASFL_OP_SUB: begin
        opb = ~op.b;
        cin = op.with_carry ? ~st.psw.c : 1'b1;
      end
      ASFL_OP_NEG: begin
        opa = 16'h0000;
        opb = ~op.a;
        cin = 1'b1;
      end
      default: begin
        cin = op.with_carry & st.psw.c;
      end
    endcase
  end

  assign carry[0] = cin;

  // one ripple stage per bit, so byte and word carries come from one chain
  generate
    for (genvar i = 0; i < 16; i++) begin : g_ripple
      assign bit_sum[i] = opa[i] ^ opb[i] ^ carry[i];
      assign carry[i+1] = (opa[i] & opb[i]) | (carry[i] & (opa[i] ^ opb[i]));
    end
  endgenerate

  assign sum = op.byte_op ? {8'h00, bit_sum[7:0]} : bit_sum;
  // byte size moves every msb and carry to bit 7
  assign add_carry = op.byte_op ? carry[8] : carry[16];
  assign msb_a = op.byte_op ? opa[7] : opa[15];
  assign msb_b = op.byte_op ? opb[7] : opb[15];
  assign msb_s = op.byte_op ? sum[7] : sum[15];
  assign msb_r = op.byte_op ? op.res[7] : op.res[15];
  assign zero_s = op.byte_op ? (sum[7:0] == 8'h00) : (sum == 16'h0000);
  assign zero_r = op.byte_op ? (op.res[7:0] == 8'h00) : (op.res == 16'h0000);
  // product must fit one word: sign copies or zero upper half
  assign mul_v = op.signed_op ? (op.wide_res[31:15] != {17{op.wide_res[15]}})
                              : (op.wide_res[31:16] != 16'h0000);
  assign min_src = op.byte_op ? (op.a[7:0] == `ASFL_MIN_BYTE) : (op.a == `ASFL_MIN_WORD);

  always_comb begin
    f = st.psw;
    f.e = op.table_src & min_src;
    f.n = msb_r;
    f.z = zero_r;
    unique case (op.kind)
      ASFL_OP_ADD, ASFL_OP_SUB, ASFL_OP_NEG: begin
        f.n = msb_s;
        // subtraction is a complement addition, borrow is no carry
        f.c = (op.kind == ASFL_OP_ADD) ? add_carry : ~add_carry;
        f.v = (msb_a == msb_b) && (msb_s != msb_a);
        f.z = op.with_carry ? (st.psw.z & zero_s) : zero_s;
      end
      ASFL_OP_LOGIC: begin
        f.c = 1'b0;
        f.v = 1'b0;
      end
      ASFL_OP_MUL: begin
        f.n = op.wide_res[31];
        f.z = (op.wide_res == 32'h0000_0000);
        f.c = 1'b0;
        f.v = mul_v;
      end
      ASFL_OP_DIV: begin
        f.c = 1'b0;
        f.v = op.div_zero | op.div_ovf;
      end
      ASFL_OP_SHL: begin
        f.c = (op.shift_cnt != 5'h00) & op.shift_out;
        f.v = 1'b0;
      end
      ASFL_OP_SHR: begin
        f.c = (op.shift_cnt != 5'h00) & op.shift_out;
        // ones lost before the last bit refine the rounding error
        f.v = (op.shift_cnt != 5'h00) & op.shift_sticky;
      end
      ASFL_OP_PRIOR: begin
        f.c = 1'b0;
        f.v = 1'b0;
        f.z = (op.b == 16'h0000);
      end
      ASFL_OP_BIT1: begin
        f.n = op.bit_x;
        f.c = 1'b0;
        f.v = 1'b0;
        f.z = ~op.bit_x;
      end
      ASFL_OP_BIT2: begin
        f.n = op.bit_x ^ op.bit_y;
        f.c = op.bit_x & op.bit_y;
        f.v = op.bit_x | op.bit_y;
        f.z = ~(op.bit_x | op.bit_y);
      end
      ASFL_OP_MOVE: begin
        f.c = st.psw.c;
        f.v = st.psw.v;
      end
      default: begin
        f = st.psw;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic setup;
  logic access;
  logic hit_psw;
  logic hit_irq;
  logic [15:0] wr;

  assign setup = psel & ~penable;
  assign access = psel & penable & st.pready;
  assign hit_psw = (paddr == `ASFL_PSW_OFFSET);
  assign hit_irq = (paddr == `ASFL_IRQ_OFFSET);
  assign wr = pwdata[15:0];

  always_comb begin
    next_st = st;
    if (op.valid) begin
      next_st.psw = f;
    end
    if (irq.return_from_interrupt_instruction) begin
      // return restores the whole word, bank included
      next_st.psw = asfl_psw_s'(irq.saved);
    end else if (irq.entry) begin
      next_st.psw.bank = irq.bank;
      next_st.psw.lvl = irq.lvl;
    end
    // software write lands last so it supersedes implicit flags
    if (access && pwrite && hit_psw) begin
      next_st.psw = asfl_psw_s'(wr);
    end
    next_st.psw.mul_in_progress_flag = 1'b0;
    // one wait-free access cycle after every setup cycle
    next_st.pready = setup;
    next_st.pslverr = setup & ~(hit_psw | hit_irq);
    next_st.prdata = 32'h0000_0000;
    if (setup && !pwrite && hit_psw) begin
      next_st.prdata = {16'h0000, st.psw};
    end else if (setup && !pwrite && hit_irq) begin
      next_st.prdata = {31'h0000_0000, st.irq_ok};
    end
    // level 15 lets only traps and non-maskable requests through
    next_st.irq_ok = req_unmaskable | (req_valid & st.psw.global_interrupt_enable & (req_lvl > st.psw.lvl));
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign processor_status_word = st.psw;
  assign irq_ok = st.irq_ok;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

endmodule

/* asfl_psw_checker.sv */
`timescale 1ns/1ps
module asfl_psw_checker
  import asfl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // core side
  input wire asfl_op_s op,
  input wire asfl_irq_s irq,
  input wire logic req_valid,
  input wire logic [3:0] req_lvl,
  input wire logic req_unmaskable,
  input wire logic [15:0] processor_status_word,
  input wire logic irq_ok
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire [15:0] p = processor_status_word;
  wire wr = psel && penable && pwrite;
  // flags are owed only when no software write or return overrides them
  wire q = op.valid && !wr && !irq.return_from_interrupt_instruction;
  wire [16:0] s = {1'b0, op.a} + {1'b0, op.b};
  a_write_wins: assert property (wr && pready && paddr == '0 |=>
    p == $past({pwdata[15:6], 1'b0, pwdata[4:0]})) else $error("write lost");
  a_logic_word: assert property (q && op.kind == ASFL_OP_LOGIC && !op.byte_op |=>
    p[3:0] == {$past(op.res == 16'h0), 2'b00, $past(op.res[15])}) else $error("word flags");
  a_logic_byte: assert property (q && op.kind == ASFL_OP_LOGIC && op.byte_op |=>
    p[3:0] == {$past(op.res[7:0] == 8'h0), 2'b00, $past(op.res[7])}) else $error("byte flags");
  a_add_cv: assert property (q && op.kind == ASFL_OP_ADD && !op.byte_op && !op.with_carry |=>
    p[2:1] == $past({~(op.a[15] ^ op.b[15]) & (s[15] ^ op.a[15]), s[16]})) else $error("add flags");
  a_bit_pair: assert property (q && op.kind == ASFL_OP_BIT2 |=>
    p[3:0] == $past({~(op.bit_x | op.bit_y), op.bit_x | op.bit_y, op.bit_x & op.bit_y, op.bit_x ^ op.bit_y}))
    else $error("bit flags");
  a_shift_round: assert property (q && op.kind == ASFL_OP_SHR && op.shift_cnt != 5'h0 |=>
    p[2:1] == $past({op.shift_sticky, op.shift_out})) else $error("shift flags");
  a_entry_load: assert property (irq.entry && !irq.return_from_interrupt_instruction && !wr |=>
    {p[15:12], p[9:8]} == $past({irq.lvl, irq.bank})) else $error("entry load");
  a_irq_gate: assert property ($past(reset_n) |->
    irq_ok == $past(req_unmaskable | (req_valid & p[11] & (req_lvl > p[15:12])))) else $error("irq gate");
endmodule
bind asfl_psw asfl_psw_checker #(.ADDR_W(ADDR_W)) asfl_psw_checker_i (.clk, .reset_n, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .op, .irq, .req_valid, .req_lvl, .req_unmaskable, .processor_status_word, .irq_ok);

/* asfl_exec_model.sv */
`timescale 1ns/1ps
module asfl_exec_model
  import asfl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // one instruction per valid cycle
  input wire asfl_op_s cmd,
  output asfl_op_s op
);
  asfl_op_s next_op;
  // stale fields flip so a dead operand never looks current
  always_comb begin
    next_op = cmd.valid ? cmd : {1'b0, ~op[$bits(op)-2:0]};
  end
  always_ff @(posedge clk) begin
    op <= reset_n ? next_op : '0;
  end
endmodule

/* asfl_psw_tb_top.sv */
`timescale 1ns/1ps
module asfl_psw_tb_top;
  import asfl_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, req_valid, req_unmaskable, irq_ok, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] req_lvl;
  logic [15:0] psw;
  asfl_op_s cmd, op, t;
  asfl_irq_s irq;
  int error_cnt, cmp_count, cyc;
  asfl_exec_model asfl_exec_model_i (.clk(clk), .reset_n(reset_n), .cmd(cmd), .op(op));
  asfl_psw asfl_psw_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op(op),
    .irq(irq), .req_valid(req_valid), .req_lvl(req_lvl), .req_unmaskable(req_unmaskable),
    .processor_status_word(psw), .irq_ok(irq_ok));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  ////////////////////
  task automatic check(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run;
    end
  end
  // instructions last one cycle
  always @(posedge clk) if (cmd.valid) cmd <= '0;
  task automatic run(input asfl_kind_e k, input logic [15:0] a, b, r, input logic [4:0] e);
    t.valid = 1;
    t.kind = k;
    t.a = a;
    t.b = b;
    t.res = r;
    @(posedge clk);
    cmd <= t;
    repeat (2) @(posedge clk);
    #1 check(psw[4:0], e);
    t = '0;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && cyc < 3000);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic judge(input logic [3:0] l, input logic u, e);
    @(posedge clk);
    req_valid <= 1;
    req_lvl <= l;
    req_unmaskable <= u;
    @(posedge clk);
    #1 check(irq_ok, e);
  endtask
  task automatic set_irq(input asfl_irq_s v, input logic [15:0] e);
    @(posedge clk);
    irq <= v;
    @(posedge clk);
    irq <= '0;
    #1 check(psw, e);
  endtask
  ////////////////////
  task automatic t_arith;
    run(ASFL_OP_ADD, 16'h7FFF, 16'h1, 16'h8000, 5'h05);
    t.with_carry = 1;
    run(ASFL_OP_ADD, 16'h0, 16'h0, 16'h0, 5'h00);
    run(ASFL_OP_ADD, 16'hFFFF, 16'h1, 16'h0, 5'h0A);
    t.div_zero = 1;
    run(ASFL_OP_DIV, 16'h1, 16'h0, 16'h1, 5'h04);
    run(ASFL_OP_SUB, 16'h0, 16'h1, 16'hFFFF, 5'h03);
    t.byte_op = 1;
    run(ASFL_OP_ADD, 16'h7F, 16'h1, 16'h80, 5'h05);
  endtask
  task automatic t_misc;
    t.shift_cnt = 5'h3;
    t.shift_out = 1;
    t.shift_sticky = 1;
    run(ASFL_OP_SHR, 16'h8, 16'h3, 16'h1, 5'h06);
    run(ASFL_OP_PRIOR, 16'h0, 16'h0, 16'h0, 5'h08);
    t.table_src = 1;
    run(ASFL_OP_LOGIC, 16'h8000, 16'h0, 16'h8000, 5'h11);
    t.table_src = 1;
    t.byte_op = 1;
    run(ASFL_OP_LOGIC, 16'h80, 16'h0, 16'h80, 5'h11);
    run(ASFL_OP_LOGIC, 16'h8000, 16'h0, 16'h1, 5'h00);
    run(ASFL_OP_NEG, 16'h8000, 16'h0, 16'h8000, 5'h07);
    t.wide_res = 32'h0001_0000;
    run(ASFL_OP_MUL, 16'h0, 16'h0, 16'h0, 5'h04);
    run(ASFL_OP_MOVE, 16'h0, 16'h0, 16'h0, 5'h0C);
    t.shift_out = 1;
    run(ASFL_OP_SHL, 16'h0, 16'h0, 16'h8000, 5'h01);
  endtask
  task automatic t_bits;
    for (int i = 0; i < 4; i++) begin
      t.bit_x = i[1];
      t.bit_y = i[0];
      run(ASFL_OP_BIT2, 16'h0, 16'h0, 16'h0, {1'b0, ~(i[1] | i[0]), i[1] | i[0], i[1] & i[0], i[1] ^ i[0]});
      t.bit_x = i[0];
      run(ASFL_OP_BIT1, 16'h0, 16'h0, 16'h0, {1'b0, ~i[0], 2'b00, i[0]});
    end
  endtask
  task automatic t_apb;
    t.valid = 1;
    t.kind = ASFL_OP_LOGIC;
    @(posedge clk);
    cmd <= t;
    apb(1, 8'h00, 32'h0000FFF7);
    t = '0;
    #1 check(psw, 16'hFFD7);
    @(posedge clk);
    apb(0, 8'h00, 32'h0);
    check(rd, 32'h0000FFD7);
    @(posedge clk);
    apb(0, 8'h40, 32'h0);
    check(er, 1'b1);
  endtask
  task automatic t_irq;
    judge(4'hF, 0, 0);
    judge(4'hF, 1, 1);
    @(posedge clk);
    apb(0, 8'h04, 32'h0);
    check(rd, 32'h0000_0001);
    set_irq({1'b1, 2'h2, 4'h5, 17'h0}, 16'h5ED7);
    judge(4'h6, 0, 1);
    judge(4'h5, 0, 0);
    set_irq({7'h0, 1'b1, 16'h0}, 16'h0000);
    judge(4'h6, 0, 0);
  endtask
  ////////////////////
  initial begin
    {psel, penable, pwrite, req_valid, req_unmaskable, reset_n, req_lvl, paddr, pwdata} = '0;
    {cmd, irq, t} = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1;
    #1 check(psw, 16'h0000);
    t_arith;
    t_misc;
    t_bits;
    t_apb;
    t_irq;
    complete_run;
  end
endmodule
